// ==== verilog/ltd_pkg.sv ====
// Shared constants, carrier types and operating summary of the two-channel time digitizer
package ltd_pkg;

  localparam int NUM_CHAN         = 2;
  localparam int BITS_PER_CHAN    = 24;
  localparam int REG_BITS         = 16;
  localparam int STAGE_BITS       = 8;
  localparam int STAGES_PER_REG   = 2;
  localparam int USED_BITS        = 12;
  localparam int REGS_PER_CHAN    = 2;
  localparam int PULSES_PER_TRAIN = 12;
  localparam int NARROW_BINS      = 23;
  localparam int CNT_W            = 5;

  // Timing of the gated train as it arrives on the pins
  localparam int GCLK_MHZ         = 500;
  localparam int BEAM_PERIOD_NS   = 32;
  localparam int GATE_OFF_NS      = 8;
  localparam int PULSE_SPACING_NS = 2;
  localparam int NARROW_BIN_NS    = 1;
  localparam int HOLD_NS          = 16;

  // Reset values and train-count limits
  localparam logic [REG_BITS-1:0]   SREG_RESET  = 16'h0000;
  localparam logic [USED_BITS-1:0]  HOLD_RESET  = 12'h000;
  localparam logic [CNT_W-1:0]      COUNT_RESET = 5'h00;
  localparam logic [CNT_W-1:0]      TRAIN_LEN   = 5'h0C;
  localparam logic [CNT_W-1:0]      COUNT_MAX   = 5'h1F;

  // Age of a set coincidence latch, counted in capture strobes
  typedef enum logic [1:0] {
    LAT_CLEAR,
    LAT_FRESH,
    LAT_AGED
  } ltd_latch_t;

  // Pins from the discriminators and the clock gating unit
  typedef struct packed {
    logic [NUM_CHAN-1:0] rear;
    logic [NUM_CHAN-1:0] front;
    logic                gclk;
    logic                capture_strobe;
    logic                shift_clear;
    logic                hold_clear;
  } ltd_pins_t;

  localparam int PIN_W = $bits(ltd_pins_t);

  // One channel's held pattern: odd register bits and even register bits
  typedef struct packed {
    logic [USED_BITS-1:0] odd;
    logic [USED_BITS-1:0] even;
  } ltd_bits_t;

endpackage

// ==== verilog/ltd_sync.sv ====
// Two-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
`default_nettype none
module ltd_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta   <= '0;
      stable <= '0;
      prev   <= '0;
    end else begin
      meta   <= async_i;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~prev;
  assign fall_o  = ~stable & prev;

endmodule
`default_nettype wire

// ==== verilog/ltd_shift8.sv ====
// One 8-bit serial-in shift stage with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module ltd_shift8 (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       shift_i,
  input  wire logic       serial_i,
  output logic      [7:0] q_o
);

  logic [7:0] next_q;

  // Bit 1 of the stage is q_o[0]; the top bit carries into the next stage
  assign next_q = {q_o[6:0], serial_i};

  always_ff @(posedge clock_i) begin
    if (rst_i || clear_i) begin
      q_o <= 8'h00;
    end else if (shift_i) begin
      q_o <= next_q;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/ltd_top.sv ====
// Two-channel latching time digitizer: coincidence latches, thermometer registers, holding flops
`timescale 1ns/1ps
`default_nettype none
module ltd_top (
  input  wire logic                                 clock_i,
  input  wire logic                                 rst_i,
  input  wire logic [ltd_pkg::NUM_CHAN-1:0]         rear_hit_i,
  input  wire logic [ltd_pkg::NUM_CHAN-1:0]         front_hit_i,
  input  wire logic                                 gated_clk_i,
  input  wire logic                                 capture_strobe_i,
  input  wire logic                                 shift_clear_i,
  input  wire logic                                 hold_clear_i,
  output ltd_pkg::ltd_bits_t [ltd_pkg::NUM_CHAN-1:0] flight_time_o,
  output logic      [ltd_pkg::NUM_CHAN-1:0]         latch_o,
  output logic      [ltd_pkg::CNT_W-1:0]            train_count_o,
  output logic                                      train_short_o,
  output logic                                      train_long_o
);
  import ltd_pkg::*;

  // ------------------------------------------------------------------
  // Pin capture
  // ------------------------------------------------------------------
  ltd_pins_t            pins_raw;
  ltd_pins_t            pins_lvl;
  ltd_pins_t            pins_rise;
  ltd_pins_t            pins_fall;

  logic [NUM_CHAN-1:0]  rear_lvl;
  logic [NUM_CHAN-1:0]  front_rise;
  logic                 gclk_rise;
  logic                 gclk_fall;
  logic                 strobe_rise;
  logic                 sclr_rise;
  logic                 hclr_rise;

  assign pins_raw.rear           = rear_hit_i;
  assign pins_raw.front          = front_hit_i;
  assign pins_raw.gclk           = gated_clk_i;
  assign pins_raw.capture_strobe = capture_strobe_i;
  assign pins_raw.shift_clear    = shift_clear_i;
  assign pins_raw.hold_clear     = hold_clear_i;

  // Every pin is asynchronous to clock_i and passes two flops first
  ltd_sync #(
    .W (PIN_W)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (pins_raw),
    .level_o (pins_lvl),
    .rise_o  (pins_rise),
    .fall_o  (pins_fall)
  );

  assign rear_lvl    = pins_lvl.rear;
  assign front_rise  = pins_rise.front;
  assign gclk_rise   = pins_rise.gclk;
  // The inverted gated clock rises where the true clock falls
  assign gclk_fall   = pins_fall.gclk;
  assign strobe_rise = pins_rise.capture_strobe;
  assign sclr_rise   = pins_rise.shift_clear;
  assign hclr_rise   = pins_rise.hold_clear;

  // ------------------------------------------------------------------
  // Pattern decode for capture, saturating pulse count for monitoring
  // ------------------------------------------------------------------
  function automatic logic [USED_BITS-1:0] used_bits(input logic [REG_BITS-1:0] r);
    used_bits = r[USED_BITS-1:0];
  endfunction

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
    bump = (c == COUNT_MAX) ? c : c + 5'h01;
  endfunction

  // ------------------------------------------------------------------
  // Per-channel logic
  // ------------------------------------------------------------------
  genvar c;
  genvar r;
  genvar s;

  generate
    for (c = 0; c < NUM_CHAN; c = c + 1) begin : g_chan
      ltd_latch_t          age;
      ltd_latch_t          next_age;
      logic                latch;
      logic                set_hit;
      logic                age_step;
      logic [REG_BITS-1:0] sreg [REGS_PER_CHAN];
      ltd_bits_t           next_hold;

      // A coincidence needs the rear level high at the front's rising edge
      assign set_hit  = front_rise[c] & rear_lvl[c];
      assign age_step = strobe_rise;

      // Once set, further hits in the period leave the latch alone;
      // the second capture strobe after setting returns it to zero
      always_comb begin
        next_age = age;
        case (age)
          LAT_CLEAR: begin
            if (set_hit) begin
              next_age = LAT_FRESH;
            end
          end
          LAT_FRESH: begin
            if (age_step) begin
              next_age = LAT_AGED;
            end
          end
          LAT_AGED: begin
            if (age_step) begin
              next_age = LAT_CLEAR;
            end
          end
          default: begin
            next_age = LAT_CLEAR;
          end
        endcase
      end

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          age   <= LAT_CLEAR;
          latch <= 1'b0;
        end else begin
          age   <= next_age;
          latch <= (next_age != LAT_CLEAR);
        end
      end

      // Register 0 is the odd register on the true clock, 1 the even one
      for (r = 0; r < REGS_PER_CHAN; r = r + 1) begin : g_reg
        logic shift_en;

        assign shift_en = (r == 0) ? gclk_rise : gclk_fall;

        for (s = 0; s < STAGES_PER_REG; s = s + 1) begin : g_stage
          logic serial;

          if (s == 0) begin : g_head
            assign serial = latch;
          end else begin : g_tail
            assign serial = sreg[r][STAGE_BITS*s-1];
          end

          ltd_shift8 u_stage (
            .clock_i  (clock_i),
            .rst_i    (rst_i),
            .clear_i  (sclr_rise),
            .shift_i  (shift_en),
            .serial_i (serial),
            .q_o      (sreg[r][STAGE_BITS*s +: STAGE_BITS])
          );
        end
      end

      // Holding flops take the used bits of both registers at once
      assign next_hold.odd  = used_bits(sreg[0]);
      assign next_hold.even = used_bits(sreg[1]);

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          flight_time_o[c] <= {HOLD_RESET, HOLD_RESET};
        end else if (strobe_rise) begin
          flight_time_o[c] <= next_hold;
        end else if (hclr_rise) begin
          flight_time_o[c] <= {HOLD_RESET, HOLD_RESET};
        end
      end

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          latch_o[c] <= 1'b0;
        end else begin
          latch_o[c] <= latch;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Train monitor: counts gated clock pulses between capture strobes
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] next_pulse_cnt;
  logic             count_short;
  logic             count_long;

  // A pulse in the strobe cycle belongs to the next train
  assign next_pulse_cnt = strobe_rise ? (gclk_rise ? 5'h01 : COUNT_RESET)
                                      : (gclk_rise ? bump(pulse_cnt) : pulse_cnt);
  assign count_short    = (pulse_cnt < TRAIN_LEN);
  assign count_long     = (pulse_cnt > TRAIN_LEN);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pulse_cnt <= COUNT_RESET;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      train_count_o <= COUNT_RESET;
      train_short_o <= 1'b0;
      train_long_o  <= 1'b0;
    end else if (strobe_rise) begin
      train_count_o <= pulse_cnt;
      train_short_o <= count_short;
      train_long_o  <= count_long;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/ltd_top_sva.sv ====
// Port-level assertions for the two-channel time digitizer
`timescale 1ns/1ps
`default_nettype none
module ltd_top_sva (
  input wire logic                                       clock_i,
  input wire logic                                       rst_i,
  input wire logic [ltd_pkg::NUM_CHAN-1:0]               rear_hit_i,
  input wire logic [ltd_pkg::NUM_CHAN-1:0]               front_hit_i,
  input wire logic                                       gated_clk_i,
  input wire logic                                       capture_strobe_i,
  input wire logic                                       shift_clear_i,
  input wire logic                                       hold_clear_i,
  input wire ltd_pkg::ltd_bits_t [ltd_pkg::NUM_CHAN-1:0] flight_time_o,
  input wire logic [ltd_pkg::NUM_CHAN-1:0]               latch_o,
  input wire logic [ltd_pkg::CNT_W-1:0]                  train_count_o,
  input wire logic                                       train_short_o,
  input wire logic                                       train_long_o
);
  import ltd_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_reset_zero: assert property (disable iff (1'b0) rst_i |=> flight_time_o == '0 && latch_o == '0)
    else $error("outputs not cleared by reset");
  chk_latch_release: assert property (($fell(latch_o[0]) || $fell(latch_o[1])) |-> $past(capture_strobe_i, 4) && !$past(capture_strobe_i, 5))
    else $error("latch released without a strobe");
  chk_set_chan0: assert property ($rose(latch_o[0]) |-> $past(front_hit_i[0], 4) && !$past(front_hit_i[0], 5) && $past(rear_hit_i[0], 4))
    else $error("channel 0 latch set without coincidence");
  chk_set_chan1: assert property ($rose(latch_o[1]) |-> $past(front_hit_i[1], 4) && !$past(front_hit_i[1], 5) && $past(rear_hit_i[1], 4))
    else $error("channel 1 latch set without coincidence");
  chk_hold_clear: assert property ($rose(hold_clear_i) && !capture_strobe_i |-> ##3 flight_time_o == '0)
    else $error("held pattern not cleared");
  chk_output_cause: assert property ($changed(flight_time_o) |-> $past(capture_strobe_i, 3) && !$past(capture_strobe_i, 4) || $past(hold_clear_i, 3) && !$past(hold_clear_i, 4))
    else $error("held pattern changed without strobe or clear");
  chk_count_cause: assert property ($changed(train_count_o) |-> $past(capture_strobe_i, 3) && !$past(capture_strobe_i, 4))
    else $error("train count changed without strobe");
  chk_train_flags: assert property ($past(capture_strobe_i, 4) && !$past(capture_strobe_i, 5) |-> train_short_o == (train_count_o < TRAIN_LEN) && train_long_o == (train_count_o > TRAIN_LEN))
    else $error("train flags disagree with count");
endmodule
bind ltd_top ltd_top_sva u_sva (
  .clock_i(clock_i), .rst_i(rst_i), .rear_hit_i(rear_hit_i), .front_hit_i(front_hit_i),
  .gated_clk_i(gated_clk_i), .capture_strobe_i(capture_strobe_i),
  .shift_clear_i(shift_clear_i), .hold_clear_i(hold_clear_i),
  .flight_time_o(flight_time_o), .latch_o(latch_o), .train_count_o(train_count_o),
  .train_short_o(train_short_o), .train_long_o(train_long_o)
);
`default_nettype wire

// ==== testbench/ltd_far_model.sv ====
// Detector discriminators and clock gating unit, slowed to the system clock
`timescale 1ns/1ps
`default_nettype none
module ltd_far_model (
  input  wire logic              clock_i,
  output var ltd_pkg::ltd_pins_t pins_o
);
  import ltd_pkg::*;
  initial pins_o = '0;
  function automatic logic in_win(input int t, input int lo, input int len);
    return (t >= lo) && (t < lo + len);
  endfunction
  // Hit slot h sits just before gated-clock toggle h; toggles every 4 cycles
  task automatic run_period(input int np, input int h [NUM_CHAN],
                            input logic [NUM_CHAN-1:0] ren, input logic dbl);
    int e;
    e = 8 + 8 * np;
    for (int t = 0; t < e + 28; t++) begin
      @(posedge clock_i);
      for (int c = 0; c < NUM_CHAN; c++) begin
        pins_o.rear[c]  <= ren[c] && (in_win(t, 4 * h[c], 10) || dbl && in_win(t, 4 * h[c] + 16, 10));
        pins_o.front[c] <= in_win(t, 4 * h[c] + 6, 3) || dbl && in_win(t, 4 * h[c] + 22, 3);
      end
      pins_o.gclk           <= t >= 8 && t < e && ((t - 8) / 4) % 2 == 0;
      pins_o.capture_strobe <= in_win(t, e + 4, 4);
      pins_o.shift_clear    <= in_win(t, e + 12, 4);
      pins_o.hold_clear     <= in_win(t, e + 20, 4);
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the two-channel time digitizer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ltd_pkg::*;
  typedef struct packed {
    ltd_bits_t [NUM_CHAN-1:0] ft;
    logic [CNT_W-1:0]         cnt;
    logic [NUM_CHAN-1:0]      lat;
  } ltd_tb_exp_t;
  logic                     clock_i = 1'b0;
  logic                     rst_i = 1'b1;
  wire ltd_pins_t           pins;
  wire ltd_bits_t [NUM_CHAN-1:0] flight_time;
  wire logic [NUM_CHAN-1:0] latch;
  wire logic [CNT_W-1:0]    train_count;
  wire logic                train_short;
  wire logic                train_long;
  int                       err_count = 0;
  int                       n_checks = 0;
  ltd_tb_exp_t              exp_q [$];
  logic [NUM_CHAN-1:0]      armed = '0;
  int                       edge_h [4] = '{0, 24, 1, 23};
  always #10 clock_i = ~clock_i;
  ltd_far_model u_far (.clock_i(clock_i), .pins_o(pins));
  ltd_top u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .rear_hit_i(pins.rear), .front_hit_i(pins.front),
    .gated_clk_i(pins.gclk), .capture_strobe_i(pins.capture_strobe),
    .shift_clear_i(pins.shift_clear), .hold_clear_i(pins.hold_clear),
    .flight_time_o(flight_time), .latch_o(latch), .train_count_o(train_count),
    .train_short_o(train_short), .train_long_o(train_long)
  );
  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Thermometer of the edges of one register that follow slot h
  function automatic logic [USED_BITS-1:0] pat(input int h, input int np, input int par);
    int n;
    n = 0;
    for (int i = h; i < 2 * np; i++) n += (i % 2 == par);
    if (n > USED_BITS) n = USED_BITS;
    return ~(12'hFFF << n);
  endfunction
  // hf: slot for channel 0, -1 random hits, -2 no coincidences
  task automatic do_period(input int np, input logic dbl, input int hf);
    int h [NUM_CHAN];
    logic [NUM_CHAN-1:0] ren;
    ltd_tb_exp_t e;
    e.cnt = np[CNT_W-1:0];
    for (int c = 0; c < NUM_CHAN; c++) begin
      h[c] = (hf >= 0 && c == 0) ? hf : $urandom_range(dbl ? 16 : 24, 0);
      ren[c] = (hf >= 0 && c == 0) || (hf != -2 && $urandom_range(3, 0) != 0);
      if (armed[c]) begin
        e.ft[c] = {pat(0, np, 0), pat(0, np, 1)};
        armed[c] = 1'b0;
      end else if (ren[c]) begin
        e.ft[c] = {pat(h[c], np, 0), pat(h[c], np, 1)};
        armed[c] = 1'b1;
      end else begin
        e.ft[c] = '0;
      end
    end
    e.lat = armed;
    exp_q.push_back(e);
    u_far.run_period(np, h, ren, dbl);
  endtask
  initial begin : monitor
    ltd_tb_exp_t e;
    forever begin
      @(posedge pins.capture_strobe);
      repeat (4) @(posedge clock_i);
      #1;
      if (exp_q.size() == 0) begin
        err_count++;
        $display("CHECK FAILED t=%0t capture with no expectation", $time);
      end else begin
        e = exp_q.pop_front();
        check(flight_time, e.ft, "pattern");
        check(train_count, e.cnt, "train count");
        check({train_short, train_long}, {e.cnt < PULSES_PER_TRAIN, e.cnt > PULSES_PER_TRAIN}, "train flags");
        check(latch, e.lat, "latch state");
      end
      @(posedge pins.hold_clear);
      repeat (4) @(posedge clock_i);
      #1;
      check(flight_time, '0, "hold clear");
    end
  end
  initial begin
    #150000;
    err_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    void'($urandom(69));
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check({flight_time, latch, train_count}, '0, "reset");
    $display("test reset done");
    for (int p = 0; p < 20; p++) do_period(12, p % 3 == 1, -1);
    $display("test random periods done");
    do_period(12, 1'b0, -2);
    do_period(12, 1'b0, -2);
    for (int k = 0; k < 4; k++) begin
      do_period(12, 1'b0, edge_h[k]);
      do_period(12, 1'b0, -2);
      do_period(12, 1'b0, -2);
    end
    $display("test boundary slots done");
    do_period(12, 1'b0, 5);
    do_period(11, 1'b0, -2);
    do_period(13, 1'b0, -2);
    $display("test train length done");
    repeat (10) @(posedge clock_i);
    check(exp_q.size(), 0, "pending captures");
    stop_test();
  end
endmodule
`default_nettype wire
